// ==== common/cdt_pkg.sv ====
// Summary of operation
// - Ready asserts within ten clocks of access
// - DMA request while FIFO has data/room
// - DMA timeout bounds request duration
// - Timeout mode: timer advances every four clocks
// - Trigger command gives one-clock trigger pulse
// - Timer delays count system clock cycles
// - Acceptor handshake timed by system clock
// - Interrupt conditions evaluated on system clock
`default_nettype none
package cdt_pkg;
	// ----------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------
	localparam logic [3:0] cdt_rdy_lat_max  = 4'h a;
	localparam logic [3:0] cdt_rdy_lat_use  = 4'h 3;
	localparam logic [1:0] cdt_dma_prescale = 2'h 3;
	localparam logic [2:0] cdt_acc_delay    = 3'h 4;
	// ----------------------------------------------------------------
	// Field layouts and commands
	// ----------------------------------------------------------------
	localparam logic [7:0] cdt_aux_trig_cmd = 8'h 0a;
	localparam logic [7:0] cdt_timer_rst    = 8'h 00;
	localparam logic [4:0] cdt_reg_addr_w   = 5'h 05;
	typedef enum logic [2:0] {
		cdt_acc_idle_st = 3'b001,
		cdt_acc_wait_st = 3'b010,
		cdt_acc_done_st = 3'b100
	} cdt_acc_state_type;
endpackage
`default_nettype wire

// ==== common/cdt_tmr_if.sv ====
`default_nettype none
interface cdt_tmr_if;
	logic       start;
	logic [7:0] limit;
	logic       expired;
	modport owner (output start, output limit, input expired);
	modport timer (input start, input limit, output expired);
endinterface
`default_nettype wire

// ==== hw/cdt_dma_timer.sv ====
`default_nettype none
module cdt_dma_timer (
	input  wire logic clk_in,
	input  wire logic arst_n_in,
	cdt_tmr_if.timer  tif
);
	logic [1:0] pre_ff;
	logic [7:0] cnt_ff;
	logic       tick;
	// ----------------------------------------------------------------
	// Prescaler: one timer count per four clocks
	// ----------------------------------------------------------------
	assign tick = (pre_ff == cdt_pkg::cdt_dma_prescale);
	assign tif.expired = (tif.limit != cdt_pkg::cdt_timer_rst)
		&& (cnt_ff >= tif.limit);
	// Counter restarts when the request drops, delay scales with clock
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			pre_ff <= 2'h 0;
			cnt_ff <= cdt_pkg::cdt_timer_rst;
		end else if (!tif.start) begin
			pre_ff <= 2'h 0;
			cnt_ff <= cdt_pkg::cdt_timer_rst;
		end else begin
			pre_ff <= pre_ff + 2'h 1;
			if (tick && !tif.expired)
				cnt_ff <= cnt_ff + 8'h 01;
		end
	end
	// Prescaler must wrap every four clocks while the request stands
	property p_tick4;
		@(posedge clk_in) disable iff (!arst_n_in)
		tif.start && tick ##1 tif.start [*3] |-> !tick;
	endproperty
	a_tick4: assert property (p_tick4)
		else $error("tick spacing");
	// Count only moves on a prescaler tick
	property p_cnt_step;
		@(posedge clk_in) disable iff (!arst_n_in)
		tif.start && !tick |=> $stable(cnt_ff);
	endproperty
	a_cnt_step: assert property (p_cnt_step)
		else $error("count off tick");
	// A dropped request clears the timeout one clock later
	property p_exp_clr;
		@(posedge clk_in) disable iff (!arst_n_in)
		!tif.start |=> !tif.expired;
	endproperty
	a_exp_clr: assert property (p_exp_clr)
		else $error("timeout stuck");
endmodule
`default_nettype wire

// ==== hw/cdt_timing.sv ====
`default_nettype none
module cdt_timing (
	input  wire logic       clk_in,
	input  wire logic       arst_n_in,
	input  wire logic       legacy_acc_in,
	input  wire logic       dma_cycle_in,
	input  wire logic       fifo_rd_avail_in,
	input  wire logic       fifo_wr_room_in,
	input  wire logic [7:0] dma_timeout_in,
	input  wire logic       aux_wr_in,
	input  wire logic [7:0] aux_data_in,
	input  wire logic       int_cond_in,
	input  wire logic       dav_in,
	output logic            rdy_stretch_out,
	output logic            dma_request_out,
	output logic            trig_out,
	output logic            int_out,
	output logic            ndac_rel_out
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] dav_sync_ff;
	logic [1:0] int_sync_ff;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			dav_sync_ff <= 2'h 0;
			int_sync_ff <= 2'h 0;
		end else begin
			dav_sync_ff <= {dav_sync_ff[0], dav_in};
			int_sync_ff <= {int_sync_ff[0], int_cond_in};
		end
	end
	// ----------------------------------------------------------------
	// Cycle ready: stretch legacy accesses only
	// ----------------------------------------------------------------
	logic [3:0] rdy_cnt_ff;
	logic [3:0] nxt_rdy_cnt;
	logic       legacy_hit;
	// DMA cycles never stretch, so a DMA engine is never stalled here
	assign legacy_hit = legacy_acc_in && !dma_cycle_in;
	assign nxt_rdy_cnt = !legacy_hit ? 4'h 0 :
		(rdy_cnt_ff == cdt_pkg::cdt_rdy_lat_use) ? rdy_cnt_ff :
		rdy_cnt_ff + 4'h 1;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			rdy_cnt_ff <= 4'h 0;
		else
			rdy_cnt_ff <= nxt_rdy_cnt;
	end
	// Host holds the cycle while this is high
	assign rdy_stretch_out = legacy_hit
		&& (rdy_cnt_ff != cdt_pkg::cdt_rdy_lat_use);
	// ----------------------------------------------------------------
	// DMA request with timeout
	// ----------------------------------------------------------------
	cdt_tmr_if tif ();
	logic dma_want;
	logic dma_req_ff;
	assign dma_want = fifo_rd_avail_in || fifo_wr_room_in;
	assign tif.start = dma_want;
	assign tif.limit = dma_timeout_in;
	cdt_dma_timer u_timer (
		.clk_in    (clk_in),
		.arst_n_in (arst_n_in),
		.tif       (tif)
	);
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			dma_req_ff <= 1'b0;
		else
			dma_req_ff <= dma_want && !tif.expired;
	end
	assign dma_request_out = dma_req_ff;
	// ----------------------------------------------------------------
	// Trigger pulse from the aux mode command write
	// ----------------------------------------------------------------
	logic trig_ff;
	logic trig_hit;
	assign trig_hit = aux_wr_in
		&& (aux_data_in == cdt_pkg::cdt_aux_trig_cmd);
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			trig_ff <= 1'b0;
		else
			trig_ff <= trig_hit && !trig_ff;
	end
	assign trig_out = trig_ff;
	// ----------------------------------------------------------------
	// Interrupt: condition sampled on the system clock
	// ----------------------------------------------------------------
	logic int_ff;
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in)
			int_ff <= 1'b0;
		else
			int_ff <= int_sync_ff[1];
	end
	assign int_out = int_ff;
	// ----------------------------------------------------------------
	// Acceptor handshake: release after a clock-counted settle
	// ----------------------------------------------------------------
	cdt_pkg::cdt_acc_state_type acc_ff;
	cdt_pkg::cdt_acc_state_type nxt_acc;
	logic [2:0] acc_cnt_ff;
	logic       acc_cnt_done;
	assign acc_cnt_done = (acc_cnt_ff == cdt_pkg::cdt_acc_delay);
	always_comb begin
		nxt_acc = acc_ff;
		unique case (acc_ff)
			cdt_pkg::cdt_acc_idle_st: begin
				if (dav_sync_ff[1])
					nxt_acc = cdt_pkg::cdt_acc_wait_st;
			end
			cdt_pkg::cdt_acc_wait_st: begin
				if (acc_cnt_done)
					nxt_acc = cdt_pkg::cdt_acc_done_st;
			end
			cdt_pkg::cdt_acc_done_st: begin
				if (!dav_sync_ff[1])
					nxt_acc = cdt_pkg::cdt_acc_idle_st;
			end
			default: nxt_acc = cdt_pkg::cdt_acc_idle_st;
		endcase
	end
	always_ff @(posedge clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			acc_ff     <= cdt_pkg::cdt_acc_idle_st;
			acc_cnt_ff <= 3'h 0;
		end else begin
			acc_ff     <= nxt_acc;
			acc_cnt_ff <= (acc_ff == cdt_pkg::cdt_acc_wait_st)
				? acc_cnt_ff + 3'h 1 : 3'h 0;
		end
	end
	assign ndac_rel_out = (acc_ff == cdt_pkg::cdt_acc_done_st);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	// Ready must show within the bounded stretch
	property p_rdy_bound;
		@(posedge clk_in) disable iff (!arst_n_in)
		$rose(legacy_hit) |-> ##[0:10] !rdy_stretch_out;
	endproperty
	a_rdy_bound: assert property (p_rdy_bound)
		else $error("ready late");
	// A fresh legacy access is stretched from its first cycle
	property p_rdy_first;
		@(posedge clk_in) disable iff (!arst_n_in)
		$rose(legacy_hit) |-> rdy_stretch_out;
	endproperty
	a_rdy_first: assert property (p_rdy_first)
		else $error("no stretch");
	// Once ready, a held access is not stretched again
	property p_rdy_hold;
		@(posedge clk_in) disable iff (!arst_n_in)
		legacy_hit && !rdy_stretch_out ##1 legacy_hit |-> !rdy_stretch_out;
	endproperty
	a_rdy_hold: assert property (p_rdy_hold)
		else $error("ready withdrawn");
	// Other and DMA cycles are never stretched
	property p_no_stretch;
		@(posedge clk_in) disable iff (!arst_n_in)
		!legacy_hit |-> !rdy_stretch_out;
	endproperty
	a_no_stretch: assert property (p_no_stretch)
		else $error("bad stretch");
	// No FIFO data or room means no request next cycle
	property p_dma_req;
		@(posedge clk_in) disable iff (!arst_n_in)
		!dma_want |=> !dma_request_out;
	endproperty
	a_dma_req: assert property (p_dma_req)
		else $error("dma req idle");
	// Data or room with time left raises the request
	property p_dma_go;
		@(posedge clk_in) disable iff (!arst_n_in)
		dma_want && !tif.expired |=> dma_request_out;
	endproperty
	a_dma_go: assert property (p_dma_go)
		else $error("dma req missing");
	// An expired timer drops the request
	property p_dma_to;
		@(posedge clk_in) disable iff (!arst_n_in)
		tif.expired |=> !dma_request_out;
	endproperty
	a_dma_to: assert property (p_dma_to)
		else $error("dma timeout");
	// Trigger pulse lasts a single clock
	property p_trig1;
		@(posedge clk_in) disable iff (!arst_n_in)
		trig_out |=> !trig_out;
	endproperty
	a_trig1: assert property (p_trig1)
		else $error("trig width");
	// The trigger command produces the pulse unless a pulse is already high
	property p_trig_go;
		@(posedge clk_in) disable iff (!arst_n_in)
		trig_hit && !trig_out |=> trig_out;
	endproperty
	a_trig_go: assert property (p_trig_go)
		else $error("trig missing");
	// No pulse without the trigger command
	property p_trig_src;
		@(posedge clk_in) disable iff (!arst_n_in)
		trig_out |-> $past(trig_hit);
	endproperty
	a_trig_src: assert property (p_trig_src)
		else $error("trig spurious");
	// Synchronised condition reaches the pin one clock later
	property p_int_lat;
		@(posedge clk_in) disable iff (!arst_n_in)
		int_sync_ff[1] |=> int_out;
	endproperty
	a_int_lat: assert property (p_int_lat)
		else $error("int lag");
	// A cleared condition clears the pin one clock later
	property p_int_clr;
		@(posedge clk_in) disable iff (!arst_n_in)
		!int_sync_ff[1] |=> !int_out;
	endproperty
	a_int_clr: assert property (p_int_clr)
		else $error("int stuck");
	// Acceptance waits out the clock-counted settle
	property p_acc;
		@(posedge clk_in) disable iff (!arst_n_in)
		$rose(acc_ff == cdt_pkg::cdt_acc_wait_st) |-> !ndac_rel_out [*5];
	endproperty
	a_acc: assert property (p_acc)
		else $error("accept early");
	// Settle count done means acceptance next clock
	property p_acc_go;
		@(posedge clk_in) disable iff (!arst_n_in)
		acc_cnt_done && acc_ff == cdt_pkg::cdt_acc_wait_st |=> ndac_rel_out;
	endproperty
	a_acc_go: assert property (p_acc_go)
		else $error("accept late");
	// Acceptance holds while data valid stays up
	property p_acc_hold;
		@(posedge clk_in) disable iff (!arst_n_in)
		ndac_rel_out && dav_sync_ff[1] |=> ndac_rel_out;
	endproperty
	a_acc_hold: assert property (p_acc_hold)
		else $error("accept dropped");
	// Idle never jumps straight to acceptance
	property p_acc_idle;
		@(posedge clk_in) disable iff (!arst_n_in)
		acc_ff == cdt_pkg::cdt_acc_idle_st |=> !ndac_rel_out;
	endproperty
	a_acc_idle: assert property (p_acc_idle)
		else $error("accept skipped");
	// Main scenarios that the bench should reach
	c_rdy: cover property (@(posedge clk_in) $fell(rdy_stretch_out));
	c_dma: cover property (@(posedge clk_in) $fell(dma_request_out));
	c_trig: cover property (@(posedge clk_in) trig_out);
	c_acc: cover property (@(posedge clk_in) ndac_rel_out);
endmodule
`default_nettype wire

// ==== verification/cdt_host_model.sv ====
`default_nettype none
// ----------------------------------------------------------------
// Host bus and command writer model
// ----------------------------------------------------------------
module cdt_host_model (
	input  wire logic       clk_in,
	input  wire logic       rdy_stretch_in,
	output logic            legacy_acc_out,
	output logic            dma_cycle_out,
	output logic            aux_wr_out,
	output logic [7:0]      aux_data_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		legacy_acc_out = 1'b0;
		dma_cycle_out = 1'b0;
		aux_wr_out = 1'b0;
		aux_data_out = 8'h00;
	end
	// Cycle is held until ready shows at an edge; bounded so a hang ends
	task automatic access(input logic dma, output int waits);
		waits = 0;
		@(posedge clk_in) #1;
		legacy_acc_out = 1'b1;
		dma_cycle_out = dma;
		do begin
			@(posedge clk_in);
			waits++;
		end while (rdy_stretch_in !== 1'b0 && waits < 40);
		#1;
		legacy_acc_out = 1'b0;
		dma_cycle_out = 1'b0;
	endtask
	// Command write; data is scrambled once released
	task automatic aux(input logic [7:0] cmd);
		repeat (4) @(posedge clk_in);
		#1;
		aux_wr_out = 1'b1;
		aux_data_out = cmd;
		@(posedge clk_in) #1;
		aux_wr_out = 1'b0;
		aux_data_out = ~cmd;
	endtask
endmodule
`default_nettype wire

// ==== verification/test_clock_derived_host_timing.sv ====
`default_nettype none
module test_clock_derived_host_timing;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0, arst_n_in = 1'b0, fifo_rd = 1'b0, fifo_wr = 1'b0;
	logic int_c = 1'b0, dav = 1'b0, leg, dma, awr, stretch, req, trig;
	logic int_o, ndac;
	logic [7:0] tmo = 8'h00, adat;
	int bad_count = 0, total_checks = 0, w, i;
	always #4 clk_in = ~clk_in;
	cdt_timing u_cdt_timing (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.legacy_acc_in(leg), .dma_cycle_in(dma), .fifo_rd_avail_in(fifo_rd),
		.fifo_wr_room_in(fifo_wr), .dma_timeout_in(tmo), .aux_wr_in(awr),
		.aux_data_in(adat), .int_cond_in(int_c), .dav_in(dav),
		.rdy_stretch_out(stretch), .dma_request_out(req), .trig_out(trig),
		.int_out(int_o), .ndac_rel_out(ndac));
	cdt_host_model u_cdt_host_model (.clk_in(clk_in),
		.rdy_stretch_in(stretch), .legacy_acc_out(leg), .dma_cycle_out(dma),
		.aux_wr_out(awr), .aux_data_out(adat));
	// ----------------------------------------------------------------
	// Shared helpers
	// ----------------------------------------------------------------
	task automatic check(input string      n,
	                     input logic [7:0] e,
	                     input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_host_cycles();
		u_cdt_host_model.access(1'b0, w);
		check("ready in time", 8'h01, {7'h00, w <= 10 && w > 1});
		u_cdt_host_model.access(1'b1, w);
		check("dma no stretch", 8'h01, {7'h00, w == 1});
	endtask
	// Timeout of 2 units must end the request near clock 8, not before
	task automatic t_dma_request();
		tmo = 8'h02;
		fifo_rd = 1'b1;
		tick(2);
		check("req on data", 8'h01, {7'h00, req});
		tick(5);
		check("req before limit", 8'h01, {7'h00, req});
		tick(7);
		check("req timed out", 8'h00, {7'h00, req});
		fifo_rd = 1'b0;
		fifo_wr = 1'b1;
		tmo = 8'h00;
		tick(14);
		check("req no timeout", 8'h01, {7'h00, req});
		fifo_wr = 1'b0;
		tick(2);
		check("req dropped", 8'h00, {7'h00, req});
	endtask
	task automatic t_trigger();
		u_cdt_host_model.aux(8'h0a);
		check("trig high", 8'h01, {7'h00, trig});
		tick(1);
		check("trig one cycle", 8'h00, {7'h00, trig});
		u_cdt_host_model.aux(8'h0b);
		check("trig other cmd", 8'h00, {7'h00, trig});
	endtask
	task automatic t_int_and_accept();
		int_c = 1'b1;
		tick(2);
		check("int early", 8'h00, {7'h00, int_o});
		tick(1);
		check("int after sync", 8'h01, {7'h00, int_o});
		int_c = 1'b0;
		dav = 1'b1;
		for (i = 0; i < 12 && ndac !== 1'b1; i++) tick(1);
		check("accept delay", 8'h01, {7'h00, ndac === 1'b1 && i >= 4});
		dav = 1'b0;
		for (i = 0; i < 8 && ndac !== 1'b0; i++) tick(1);
		check("accept release", 8'h00, {7'h00, ndac});
		check("int cleared", 8'h00, {7'h00, int_o});
	endtask
	// Watchdog sized well beyond the fewer than one hundred cycles the run needs
	initial begin
		#20us;
		bad_count++;
		report_and_stop();
	end
	initial begin
		repeat (20) @(posedge clk_in);
		#1;
		arst_n_in = 1'b1;
		t_host_cycles();
		t_dma_request();
		t_trigger();
		t_int_and_accept();
		report_and_stop();
	end
endmodule
`default_nettype wire
